// File: adsr_regs.sv
`timescale 1ns/10ps
module adsr_regs #(
  parameter logic [2:0] VERSION = adsr_pkg::VERSION_DEF
) (
  input  wire logic                        REF_CLK_I,
  input  wire logic                        RSTN_I,
  input  wire logic                        REG_WR_I,
  input  wire logic                        REG_RD_I,
  input  wire logic [7:0]                  REG_ADDR_I,
  input  wire logic [7:0]                  REG_WDATA_I,
  input  wire logic                        PWM_PULSE_I,
  input  wire logic                        ADC_OUT_READ_I,
  input  wire logic                        ADC_PERIOD_TICK_I,
  input  wire logic [adsr_pkg::CNT_W-1:0]  COUNTER_I,
  output logic                             REG_RVALID_O,
  output logic [15:0]                      REG_RDATA_O,
  output logic                             ALIGN_PULSE_O,
  output logic                             SNAP_PULSE_O,
  output logic                             PWM_GATED_O,
  output logic [2:0]                       SLOT_INDEX_O
);
  import adsr_pkg::*;

  adsr_state_s q, d;
  adsr_req_s   req;

  // ----------------------------------------------------------------
  // state after reset
  // ----------------------------------------------------------------
  localparam adsr_state_s STATE_RST = '{
    cmd:      ALIGN_CMD_RST,
    slot_en:  SLOT_GATE_RST,
    missed:   1'b0,
    accessed: 1'b0,
    capture:  CAPTURE_RST,
    div:      2'h0,
    slot:     3'h0,
    pwm_out:  1'b0,
    rsp:      '{rvalid: 1'b0, rdata: 16'h0000}
  };

  // ----------------------------------------------------------------
  // bus request
  // ----------------------------------------------------------------
  assign req = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I, wdata: REG_WDATA_I};

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // true when the request targets address a
  function automatic logic hit(
    input adsr_req_s  r,
    input logic [7:0] a
  );
    hit = (r.addr == a);
  endfunction : hit

  // true for a write strobe to address a
  function automatic logic wr_hit(
    input adsr_req_s  r,
    input logic [7:0] a
  );
    wr_hit = r.wr && hit(r, a);
  endfunction : wr_hit

  // true for a read strobe to address a
  function automatic logic rd_hit(
    input adsr_req_s  r,
    input logic [7:0] a
  );
    rd_hit = r.rd && hit(r, a);
  endfunction : rd_hit

  // ----------------------------------------------------------------
  // command pulses
  // ----------------------------------------------------------------
  // command bits live for exactly one clock; reserved bits are dropped
  function automatic logic [1:0] cmd_next(
    input adsr_req_s r
  );
    cmd_next = 2'h0;
    if (wr_hit(r, ADDR_ALIGN_CMD)) begin
      cmd_next = r.wdata[1:0];
    end
  endfunction : cmd_next

  // ----------------------------------------------------------------
  // quarter-rate slot sequencer
  // ----------------------------------------------------------------
  // divider of the input clock; the sync pulse restarts it
  function automatic logic [1:0] div_next(
    input logic       sync,
    input logic [1:0] div
  );
    if (sync) begin
      div_next = 2'h0;
    end else begin
      div_next = div + 2'h1;
    end
  endfunction : div_next

  // slot steps once per quarter-rate period; the sync pulse restarts it
  function automatic logic [2:0] slot_next(
    input logic       sync,
    input logic [1:0] div,
    input logic [2:0] slot
  );
    slot_next = slot;
    if (sync) begin
      slot_next = 3'h0;
    end else if (div == 2'(SLOT_DIV - 1)) begin
      slot_next = slot + 3'h1;
    end
  endfunction : slot_next

  // the PWM pulse passes only in an enabled slot
  function automatic logic gate(
    input logic       pulse,
    input logic [7:0] en,
    input logic [2:0] slot
  );
    gate = pulse & en[slot];
  endfunction : gate

  // ----------------------------------------------------------------
  // missed-read tracking
  // ----------------------------------------------------------------
  // a period tick opens a new period; an access inside it is remembered
  function automatic logic accessed_next(
    input logic tick,
    input logic rd_out,
    input logic accessed
  );
    accessed_next = accessed;
    if (tick) begin
      accessed_next = 1'b0;
    end else if (rd_out) begin
      accessed_next = 1'b1;
    end
  endfunction : accessed_next

  // a period with no access sets the flag; set wins over the read clear
  function automatic logic missed_next(
    input logic tick,
    input logic rd_out,
    input logic accessed,
    input logic rd_flags,
    input logic missed
  );
    missed_next = missed;
    if (rd_flags) begin
      missed_next = 1'b0;
    end
    if (tick && !accessed && !rd_out) begin
      missed_next = 1'b1;
    end
  endfunction : missed_next

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read word of each register; unmapped addresses read zero
  function automatic logic [15:0] read_word(
    input adsr_state_s s,
    input logic [7:0]  a
  );
    case (a)
      ADDR_CAPTURE:    read_word = {4'h0, s.capture};
      ADDR_ALIGN_CMD:  read_word = {14'h0000, s.cmd};
      ADDR_SLOT_GATE:  read_word = {8'h00, s.slot_en};
      ADDR_COND_FLAGS: read_word = {12'h000, s.missed, VERSION};
      default:         read_word = 16'h0000;
    endcase
  endfunction : read_word

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.cmd      = cmd_next(req);
    if (q.cmd[BIT_SNAP]) begin
      d.capture = COUNTER_I;
    end
    if (wr_hit(req, ADDR_SLOT_GATE)) begin
      d.slot_en = req.wdata;
    end
    d.div      = div_next(q.cmd[BIT_SYNC], q.div);
    d.slot     = slot_next(q.cmd[BIT_SYNC], q.div, q.slot);
    d.pwm_out  = gate(PWM_PULSE_I, q.slot_en, q.slot);
    d.accessed = accessed_next(ADC_PERIOD_TICK_I, ADC_OUT_READ_I, q.accessed);
    d.missed   = missed_next(ADC_PERIOD_TICK_I, ADC_OUT_READ_I, q.accessed,
                             rd_hit(req, ADDR_COND_FLAGS), q.missed);
    d.rsp.rvalid = req.rd;
    d.rsp.rdata  = 16'h0000;
    if (req.rd) begin
      d.rsp.rdata = read_word(q, req.addr);
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign REG_RVALID_O  = q.rsp.rvalid;
  assign REG_RDATA_O   = q.rsp.rdata;
  assign ALIGN_PULSE_O = q.cmd[BIT_SYNC];
  assign SNAP_PULSE_O  = q.cmd[BIT_SNAP];
  assign PWM_GATED_O   = q.pwm_out;
  assign SLOT_INDEX_O  = q.slot;
endmodule : adsr_regs

// File: adsr_pkg.sv
package adsr_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CAPTURE    = 8'h07;
  localparam logic [7:0]  ADDR_ALIGN_CMD  = 8'h0b;
  localparam logic [7:0]  ADDR_SLOT_GATE  = 8'h0e;
  localparam logic [7:0]  ADDR_COND_FLAGS = 8'h0f;

  localparam int          BIT_SYNC        = 0;
  localparam int          BIT_SNAP        = 1;
  localparam int          BIT_MISSED      = 3;
  localparam int          CNT_W           = 12;
  localparam int          SLOT_DIV        = 4;

  localparam logic [7:0]  SLOT_GATE_RST   = 8'hff;
  localparam logic [1:0]  ALIGN_CMD_RST   = 2'h0;
  localparam logic [11:0] CAPTURE_RST     = 12'h000;
  // version code value is arbitrary
  localparam logic [2:0]  VERSION_DEF     = 3'h1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adsr_req_s;

  typedef struct packed {
    logic        rvalid;
    logic [15:0] rdata;
  } adsr_rsp_s;

  typedef struct packed {
    logic [1:0]  cmd;
    logic [7:0]  slot_en;
    logic        missed;
    logic        accessed;
    logic [11:0] capture;
    logic [1:0]  div;
    logic [2:0]  slot;
    logic        pwm_out;
    adsr_rsp_s   rsp;
  } adsr_state_s;
endpackage : adsr_pkg

// File: adsr_regs_sva.sv
`timescale 1ns/10ps
module adsr_regs_sva (
  input wire logic        REF_CLK_I, RSTN_I, REG_RD_I, REG_WR_I, REG_RVALID_O,
  input wire logic        ALIGN_PULSE_O, SNAP_PULSE_O, PWM_PULSE_I, PWM_GATED_O,
  input wire logic        ADC_PERIOD_TICK_I,
  input wire logic [7:0]  REG_ADDR_I, REG_WDATA_I,
  input wire logic [15:0] REG_RDATA_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  wire [1:0] k = {2{REG_WR_I && REG_ADDR_I == 8'h0b}} & REG_WDATA_I[1:0];
  property p_sy; k[0] |=> ALIGN_PULSE_O ##1 !ALIGN_PULSE_O; endproperty
  a_sy: assert property (p_sy) else $error("sync");
  property p_sn; k[1] |=> SNAP_PULSE_O ##1 !SNAP_PULSE_O; endproperty
  a_sn: assert property (p_sn) else $error("snap");
  property p_ns; !k[0] |=> !ALIGN_PULSE_O; endproperty
  a_ns: assert property (p_ns) else $error("sync");
  property p_nn; !k[1] |=> !SNAP_PULSE_O; endproperty
  a_nn: assert property (p_nn) else $error("snap");
  property p_rv; REG_RVALID_O == $past(REG_RD_I); endproperty
  a_rv: assert property (p_rv) else $error("valid");
  property p_fl; REG_RD_I && REG_ADDR_I == 8'h0f |=> REG_RDATA_O[15:4] == 12'h0; endproperty
  a_fl: assert property (p_fl) else $error("flags");
  property p_rc;
    (REG_RD_I && REG_ADDR_I == 8'h0f && !ADC_PERIOD_TICK_I) ##1 (!ADC_PERIOD_TICK_I) ##1
    (REG_RD_I && REG_ADDR_I == 8'h0f) |=> !REG_RDATA_O[3];
  endproperty
  a_rc: assert property (p_rc) else $error("flag clear");
  property p_cp; REG_RD_I && REG_ADDR_I == 8'h07 |=> REG_RDATA_O[15:12] == 4'h0; endproperty
  a_cp: assert property (p_cp) else $error("capture");
  property p_pw; !PWM_PULSE_I |=> !PWM_GATED_O; endproperty
  a_pw: assert property (p_pw) else $error("gate");
  c_cm: cover property (ALIGN_PULSE_O && SNAP_PULSE_O);
  c_fl: cover property (REG_RVALID_O && REG_RDATA_O[3]);
  c_pw: cover property (PWM_GATED_O);
endmodule : adsr_regs_sva

// File: adsr_host.sv
`timescale 1ns/10ps
module adsr_host (
  input wire logic   clk_i,
  output logic       wr_o = 0, rd_o = 0,
  output logic [7:0] a_o = 0, d_o = 0
);
  // one strobe cycle, then address and data turn to their inverse
  task automatic wr(input logic [7:0] a, d, input logic r = 0);
    @(posedge clk_i) {wr_o, rd_o, a_o, d_o} <= {~r, r, a, d};
    @(posedge clk_i) {wr_o, rd_o, a_o, d_o} <= {2'b00, ~a, ~d};
  endtask : wr
endmodule : adsr_host

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import adsr_pkg::*;
  logic REF_CLK_I = 0, RSTN_I = 0, REG_WR_I, REG_RD_I, PWM_PULSE_I = 0, ADC_OUT_READ_I = 0, ADC_PERIOD_TICK_I = 0;
  logic REG_RVALID_O, ALIGN_PULSE_O, SNAP_PULSE_O, PWM_GATED_O;
  logic [7:0] REG_ADDR_I, REG_WDATA_I, v;
  logic [11:0] COUNTER_I = 0;
  logic [15:0] REG_RDATA_O;
  logic [2:0] SLOT_INDEX_O;
  int failures = 0, total_checks = 0, seed = 32'h1353;
  adsr_regs DUT (.*);
  adsr_host host (.clk_i(REF_CLK_I), .wr_o(REG_WR_I), .rd_o(REG_RD_I), .a_o(REG_ADDR_I), .d_o(REG_WDATA_I));
  initial forever #5 REF_CLK_I = ~REF_CLK_I;
  task automatic chk(input string n, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) failures++;
    if (s !== e) $display("FAIL %s exp %h got %h", n, e, s);
  endtask : chk
  function automatic logic [2:0] slot_at(input int n);
    slot_at = 3'(n / SLOT_DIV);
  endfunction : slot_at
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    host.wr(a, 8'h00, 1'b1);
    #1 chk($sformatf("reg %h", a), REG_RDATA_O & {8'hff, a != 8'h0f, 7'h7f}, e);
  endtask : rc
  task automatic conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial begin
    #30us failures++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge REF_CLK_I);
    RSTN_I <= 1;
    rc(8'h0e, 16'h00ff);
    rc(8'h03, 16'h0000);
    repeat (8) begin
      v = 8'($random(seed));
      host.wr(8'h0e, v);
      rc(8'h0e, {8'h00, v});
    end
    $display("register test done");
    host.wr(8'h0e, 8'h00);
    PWM_PULSE_I <= 1;
    repeat (9) @(posedge REF_CLK_I);
    #1 chk("gated", {15'h0, PWM_GATED_O}, 16'h0);
    v = 8'($random(seed));
    host.wr(8'h0e, v);
    host.wr(8'h0b, 8'h01);
    #1 chk("align", {15'h0, ALIGN_PULSE_O}, 16'h0001);
    @(posedge REF_CLK_I);
    for (int i = 2; i <= 41; i++) begin
      @(posedge REF_CLK_I);
      #1 chk("slot", {13'h0, SLOT_INDEX_O}, {13'h0, slot_at(i - 1)});
      chk("pulse", {15'h0, PWM_GATED_O}, {15'h0, v[slot_at(i - 2)]});
    end
    $display("slot test done");
    COUNTER_I <= 12'($random(seed));
    host.wr(8'h0b, 8'h03);
    rc(8'h07, {4'h0, COUNTER_I});
    rc(8'h0b, 16'h0000);
    $display("command test done");
    ADC_PERIOD_TICK_I <= 1;
    @(posedge REF_CLK_I) ADC_PERIOD_TICK_I <= 0;
    rc(8'h0f, {13'h0001, VERSION_DEF});
    rc(8'h0f, {13'h0000, VERSION_DEF});
    {ADC_OUT_READ_I, ADC_PERIOD_TICK_I} <= 2'b11;
    @(posedge REF_CLK_I) {ADC_OUT_READ_I, ADC_PERIOD_TICK_I} <= 2'b00;
    rc(8'h0f, {13'h0000, VERSION_DEF});
    $display("flag test done");
    conclude();
  end
endmodule : tb_top
bind adsr_regs adsr_regs_sva u_sva (.*);
